/* File: hw/ufam_pkg.sv */
// constants, enumerations and carriers for the enhanced serial port with address match
// assumes an axi4-lite master with 32-bit data on the register side
package ufam_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] UFAM_OFF_BUF = 8'h00;
  localparam logic [7:0] UFAM_OFF_CTRL = 8'h04;
  localparam logic [7:0] UFAM_OFF_PWR = 8'h08;
  localparam logic [7:0] UFAM_OFF_SLAVE_OWN_ADDRESS = 8'h0C;
  localparam logic [7:0] UFAM_OFF_SMASK = 8'h10;
  localparam logic [7:0] UFAM_OFF_IRQ_ST = 8'h14;
  localparam logic [7:0] UFAM_OFF_IRQ_CLR = 8'h18;
  localparam logic [7:0] UFAM_OFF_IRQ_EN = 8'h1C;
  localparam logic [7:0] UFAM_OFF_DIV = 8'h20;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int UFAM_CTRL_MODE_HI = 7;
  localparam int UFAM_CTRL_MODE_LO = 6;
  localparam int UFAM_CTRL_MPC = 5;
  localparam int UFAM_CTRL_REN = 4;
  localparam int UFAM_CTRL_TB8 = 3;
  localparam int UFAM_CTRL_RB8 = 2;
  localparam int UFAM_CTRL_TI = 1;
  localparam int UFAM_CTRL_RI = 0;
  localparam int UFAM_PWR_FE = 1;
  localparam int UFAM_PWR_STOPCHK = 0;
  localparam int UFAM_IRQ_RX = 0;
  localparam int UFAM_IRQ_TX = 1;
  localparam int UFAM_IRQ_FE = 2;

  // ----------------------------------------
  // reset values, modes, answers
  // ----------------------------------------
  localparam logic [7:0] UFAM_ADDR_RST = 8'h00;
  localparam logic [7:0] UFAM_MASK_RST = 8'h00;
  localparam logic [15:0] UFAM_DIV_RST = 16'h0010;
  localparam logic [1:0] UFAM_MODE_SHIFT = 2'h0;
  localparam logic [1:0] UFAM_MODE_ASYNC8 = 2'h1;
  localparam logic [3:0] UFAM_LAST_SHIFT = 4'h7;
  localparam logic [3:0] UFAM_LAST_ASYNC8 = 4'h9;
  localparam logic [3:0] UFAM_LAST_ASYNC9 = 4'hA;
  localparam logic [1:0] UFAM_RESP_OKAY = 2'h0;
  localparam logic [1:0] UFAM_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {UFAM_TX_IDLE, UFAM_TX_RUN} ufam_tx_e;
  typedef enum logic [2:0] {UFAM_RX_IDLE, UFAM_RX_START, UFAM_RX_DATA, UFAM_RX_STOP, UFAM_RX_SHIFT} ufam_rx_e;

  // ----------------------------------------
  // bus carriers
  // ----------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } ufam_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ufam_axil_rsp_s;

endpackage

/* File: hw/ufam_uart.sv */
// enhanced serial port: four modes, stop bit check, automatic address match
// assumes one 250 MHz clock, synchronous reset, axi4-lite master, serial pins from outside
//
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - transmit and receive paths run concurrently in modes 1-3; mode 0 receive waits for transmit idle
// - buffer write loads transmit, read returns receive
// - two mode bits pick one of four modes
// - any buffer write with the low byte strobe set starts a transmission
// - mode 0 receive starts: done clear, enable set
// - other modes receive on start bit when enabled
// - stop bit checked only in modes 1-3
// - stop-check select bit enables framing check
// - framing error sticky until software clears it
// - with check on, done rises at stop
// - compare bit: done only on address match
// - ninth bit marks address; slave clears compare
// - mode 1 compare uses valid stop bit
// - mode 0 ignores compare bit
// - mask zero bits are don't-care for given address
// - broadcast is address OR mask, zeros ignored
// - address and mask reset to zero
module ufam_uart
  import ufam_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire ufam_axil_req_s axil_req,
  output ufam_axil_rsp_s axil_rsp,
  input wire logic ser_data_in,
  output logic ser_data_out,
  output logic ser_data_oe,
  output logic ser_tx,
  output logic irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    ufam_axil_rsp_s rsp;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] mode;
    logic mpc;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
    logic stop_chk;
    logic fe;
    logic [7:0] slave_own_address;
    logic [7:0] smask;
    logic [15:0] div;
    logic [2:0] irq_st;
    logic [2:0] irq_en;
    logic irq;
    logic [7:0] rx_buf;
    ufam_tx_e tx_st;
    logic [10:0] tx_sh;
    logic [3:0] tx_cnt;
    logic [3:0] tx_last;
    logic [15:0] tx_tmr;
    logic tx_m0;
    ufam_rx_e rx_st;
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    logic [15:0] rx_tmr;
    logic rxd_s1;
    logic rxd_s2;
    logic rxd_prev;
    logic ser_tx;
    logic ser_data_out;
    logic ser_data_oe;
  } ufam_state_s;

  ufam_state_s st_r;
  ufam_state_s st_nxt;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic addr_match(input logic [7:0] d, input logic [7:0] sa, input logic [7:0] sm);
    logic [7:0] bc;
    bc = sa | sm;
    // reset zeros make both forms all don't-care
    addr_match = (((d ^ sa) & sm) == 8'h00)
      || ((d & bc) == bc);
  endfunction

  function automatic logic rx_accept(input logic [1:0] m, input logic mpc, input logic marker,
                                     input logic [7:0] d, input logic [7:0] sa, input logic [7:0] sm);
    // mode 0 never reaches here, so the compare bit cannot filter it
    if (!mpc) begin
      rx_accept = 1'b1;
    end else begin
      // marker is ninth bit in modes 2/3, stop bit in mode 1
      rx_accept = marker && addr_match(d, sa, sm);
    end
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic wr_do;
    logic [7:0] wa;
    logic [7:0] wb;
    logic [31:0] rd;
    logic rd_err;
    logic [15:0] half;
    logic set_ri;
    logic set_ti;
    logic set_fe;
    logic at_stop;
    logic [8:0] sh;
    logic [7:0] rx_d;
    logic rx_mark;
    logic clk_low;
    wr_do = 1'b0;
    wa = 8'h00;
    wb = 8'h00;
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    half = {1'b0, st_r.div[15:1]};
    set_ri = 1'b0;
    set_ti = 1'b0;
    set_fe = 1'b0;
    at_stop = st_r.stop_chk || (st_r.mode == UFAM_MODE_ASYNC8 && st_r.mpc);
    sh = st_r.rx_sh;
    rx_d = 8'h00;
    rx_mark = 1'b0;
    clk_low = 1'b0;
    st_nxt = st_r;

    // pin synchroniser, first stage read only by second
    st_nxt.rxd_s1 = ser_data_in;
    st_nxt.rxd_s2 = st_r.rxd_s1;
    st_nxt.rxd_prev = st_r.rxd_s2;

    // ----------------------------------------
    // bus write side
    // ----------------------------------------
    if (axil_req.awvalid && st_r.rsp.awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && st_r.rsp.wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = axil_req.wdata;
      st_nxt.w_strb = axil_req.wstrb;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.rsp.bvalid) begin
      wr_do = 1'b1;
      wa = st_r.aw_addr;
      wb = st_r.w_data[7:0];
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp = UFAM_RESP_OKAY;
      case ({wa[7:2], 2'b00})
        UFAM_OFF_BUF, UFAM_OFF_CTRL, UFAM_OFF_PWR, UFAM_OFF_SLAVE_OWN_ADDRESS, UFAM_OFF_SMASK,
        UFAM_OFF_IRQ_CLR, UFAM_OFF_IRQ_EN, UFAM_OFF_DIV: st_nxt.rsp.bresp = UFAM_RESP_OKAY;
        default: st_nxt.rsp.bresp = UFAM_RESP_SLVERR;
      endcase
    end
    if (st_r.rsp.bvalid && axil_req.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end
    if (wr_do && st_r.w_strb[0]) begin
      case ({wa[7:2], 2'b00})
        UFAM_OFF_BUF: begin
          // load transmit side and start framing in any mode
          st_nxt.tx_st = UFAM_TX_RUN;
          st_nxt.tx_cnt = 4'h0;
          st_nxt.tx_tmr = st_r.div - 16'h0001;
          st_nxt.tx_m0 = (st_r.mode == UFAM_MODE_SHIFT);
          case (st_r.mode)
            UFAM_MODE_SHIFT: begin
              st_nxt.tx_sh = {3'b111, wb};
              st_nxt.tx_last = UFAM_LAST_SHIFT;
            end
            UFAM_MODE_ASYNC8: begin
              st_nxt.tx_sh = {2'b11, wb, 1'b0};
              st_nxt.tx_last = UFAM_LAST_ASYNC8;
            end
            default: begin
              st_nxt.tx_sh = {1'b1, st_r.tb8, wb, 1'b0};
              st_nxt.tx_last = UFAM_LAST_ASYNC9;
            end
          endcase
        end
        UFAM_OFF_CTRL: begin
          st_nxt.mode = {wb[UFAM_CTRL_MODE_HI], wb[UFAM_CTRL_MODE_LO]};
          st_nxt.mpc = wb[UFAM_CTRL_MPC];
          st_nxt.ren = wb[UFAM_CTRL_REN];
          st_nxt.tb8 = wb[UFAM_CTRL_TB8];
          st_nxt.rb8 = wb[UFAM_CTRL_RB8];
          st_nxt.ti = wb[UFAM_CTRL_TI];
          st_nxt.ri = wb[UFAM_CTRL_RI];
        end
        UFAM_OFF_PWR: begin
          st_nxt.stop_chk = wb[UFAM_PWR_STOPCHK];
          st_nxt.fe = wb[UFAM_PWR_FE];
        end
        UFAM_OFF_SLAVE_OWN_ADDRESS: st_nxt.slave_own_address = wb;
        UFAM_OFF_SMASK: st_nxt.smask = wb;
        UFAM_OFF_IRQ_CLR: st_nxt.irq_st = st_r.irq_st & ~wb[2:0];
        UFAM_OFF_IRQ_EN: st_nxt.irq_en = wb[2:0];
        UFAM_OFF_DIV: st_nxt.div[7:0] = wb;
        default: st_nxt.irq_en = st_nxt.irq_en;
      endcase
    end
    if (wr_do && st_r.w_strb[1] && {wa[7:2], 2'b00} == UFAM_OFF_DIV) begin
      st_nxt.div[15:8] = st_r.w_data[15:8];
    end
    st_nxt.rsp.awready = !st_nxt.aw_got && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready = !st_nxt.w_got && !st_nxt.rsp.bvalid;

    // ----------------------------------------
    // bus read side
    // ----------------------------------------
    if (axil_req.arvalid && st_r.rsp.arready) begin
      case ({axil_req.araddr[7:2], 2'b00})
        UFAM_OFF_BUF: rd = {24'h000000, st_r.rx_buf};
        UFAM_OFF_CTRL: rd = {24'h000000, st_r.mode, st_r.mpc, st_r.ren, st_r.tb8, st_r.rb8, st_r.ti, st_r.ri};
        UFAM_OFF_PWR: rd = {30'h0, st_r.fe, st_r.stop_chk};
        UFAM_OFF_SLAVE_OWN_ADDRESS: rd = {24'h000000, st_r.slave_own_address};
        UFAM_OFF_SMASK: rd = {24'h000000, st_r.smask};
        UFAM_OFF_IRQ_ST: rd = {29'h0, st_r.irq_st};
        UFAM_OFF_IRQ_CLR: rd = 32'h0000_0000;
        UFAM_OFF_IRQ_EN: rd = {29'h0, st_r.irq_en};
        UFAM_OFF_DIV: rd = {16'h0000, st_r.div};
        default: rd_err = 1'b1;
      endcase
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rdata = rd;
      st_nxt.rsp.rresp = rd_err ? UFAM_RESP_SLVERR : UFAM_RESP_OKAY;
    end else if (st_r.rsp.rvalid && axil_req.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
    end
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;

    // ----------------------------------------
    // transmit path, independent of receive
    // ----------------------------------------
    if (st_r.tx_st == UFAM_TX_RUN && !(wr_do && {wa[7:2], 2'b00} == UFAM_OFF_BUF && st_r.w_strb[0])) begin
      if (st_r.tx_tmr == 16'h0000) begin
        st_nxt.tx_tmr = st_r.div - 16'h0001;
        if (st_r.tx_cnt == st_r.tx_last) begin
          st_nxt.tx_st = UFAM_TX_IDLE;
          set_ti = 1'b1;
        end else begin
          st_nxt.tx_sh = {1'b1, st_r.tx_sh[10:1]};
          st_nxt.tx_cnt = st_r.tx_cnt + 4'h1;
        end
      end else begin
        st_nxt.tx_tmr = st_r.tx_tmr - 16'h0001;
      end
    end

    // ----------------------------------------
    // receive path
    // ----------------------------------------
    case (st_r.rx_st)
      UFAM_RX_IDLE: begin
        if (st_r.mode == UFAM_MODE_SHIFT) begin
          // shift mode waits for done clear and enable, and an idle transmitter
          if (st_r.ren && !st_r.ri && st_r.tx_st == UFAM_TX_IDLE) begin
            st_nxt.rx_st = UFAM_RX_SHIFT;
            st_nxt.rx_cnt = 4'h0;
            st_nxt.rx_tmr = st_r.div - 16'h0001;
          end
        end else if (st_r.ren && st_r.rxd_prev && !st_r.rxd_s2) begin
          st_nxt.rx_st = UFAM_RX_START;
          st_nxt.rx_cnt = 4'h0;
          st_nxt.rx_tmr = half;
        end
      end
      UFAM_RX_START: begin
        if (st_r.rx_tmr == 16'h0000) begin
          // a glitch shorter than half a bit is dropped here
          st_nxt.rx_st = st_r.rxd_s2 ? UFAM_RX_IDLE : UFAM_RX_DATA;
          st_nxt.rx_tmr = st_r.div - 16'h0001;
        end else begin
          st_nxt.rx_tmr = st_r.rx_tmr - 16'h0001;
        end
      end
      UFAM_RX_DATA: begin
        if (st_r.rx_tmr == 16'h0000) begin
          st_nxt.rx_tmr = st_r.div - 16'h0001;
          sh = {st_r.rxd_s2, st_r.rx_sh[8:1]};
          st_nxt.rx_sh = sh;
          st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
          if (st_r.rx_cnt == ((st_r.mode == UFAM_MODE_ASYNC8) ? 4'h7 : 4'h8)) begin
            st_nxt.rx_st = UFAM_RX_STOP;
            rx_d = (st_r.mode == UFAM_MODE_ASYNC8) ? sh[8:1] : sh[7:0];
            // without the check or a mode 1 compare, done rises at the last data bit
            if (!at_stop && !st_r.ri
                && rx_accept(st_r.mode, st_r.mpc, sh[8], rx_d, st_r.slave_own_address, st_r.smask)) begin
              set_ri = 1'b1;
              st_nxt.rx_buf = rx_d;
              st_nxt.rb8 = sh[8];
            end
          end
        end else begin
          st_nxt.rx_tmr = st_r.rx_tmr - 16'h0001;
        end
      end
      UFAM_RX_STOP: begin
        if (st_r.rx_tmr == 16'h0000) begin
          st_nxt.rx_st = UFAM_RX_IDLE;
          rx_d = (st_r.mode == UFAM_MODE_ASYNC8) ? st_r.rx_sh[8:1] : st_r.rx_sh[7:0];
          rx_mark = (st_r.mode == UFAM_MODE_ASYNC8) ? st_r.rxd_s2 : st_r.rx_sh[8];
          // only async modes reach the stop bit
          if (st_r.stop_chk && !st_r.rxd_s2) begin
            set_fe = 1'b1;
          end
          if (at_stop && !st_r.ri
              && rx_accept(st_r.mode, st_r.mpc, rx_mark, rx_d, st_r.slave_own_address, st_r.smask)) begin
            set_ri = 1'b1;
            st_nxt.rx_buf = rx_d;
            st_nxt.rb8 = (st_r.mode == UFAM_MODE_ASYNC8) ? st_r.rxd_s2 : st_r.rx_sh[8];
          end
        end else begin
          st_nxt.rx_tmr = st_r.rx_tmr - 16'h0001;
        end
      end
      UFAM_RX_SHIFT: begin
        // sample at the rising edge of the shift clock, mid-bit
        if (st_r.rx_tmr == half) begin
          st_nxt.rx_sh = {st_r.rxd_s2, st_r.rx_sh[8:1]};
        end
        if (st_r.rx_tmr == 16'h0000) begin
          st_nxt.rx_tmr = st_r.div - 16'h0001;
          st_nxt.rx_cnt = st_r.rx_cnt + 4'h1;
          if (st_r.rx_cnt == UFAM_LAST_SHIFT) begin
            st_nxt.rx_st = UFAM_RX_IDLE;
            st_nxt.rx_buf = st_r.rx_sh[8:1];
            set_ri = 1'b1;
          end
        end else begin
          st_nxt.rx_tmr = st_r.rx_tmr - 16'h0001;
        end
      end
      default: st_nxt.rx_st = UFAM_RX_IDLE;
    endcase

    // ----------------------------------------
    // flags and interrupt: hardware set wins over a software clear
    // ----------------------------------------
    if (set_ri) begin
      st_nxt.ri = 1'b1;
    end
    if (set_ti) begin
      st_nxt.ti = 1'b1;
    end
    if (set_fe) begin
      st_nxt.fe = 1'b1;
    end
    st_nxt.irq_st = st_nxt.irq_st | {set_fe, set_ti, set_ri};
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_en);

    // ----------------------------------------
    // pins
    // ----------------------------------------
    clk_low = (st_nxt.tx_st == UFAM_TX_RUN && st_nxt.tx_m0 && st_nxt.tx_tmr > half)
      || (st_nxt.rx_st == UFAM_RX_SHIFT && st_nxt.rx_tmr > half);
    if (st_nxt.tx_st == UFAM_TX_RUN && st_nxt.tx_m0) begin
      st_nxt.ser_tx = !clk_low;
      st_nxt.ser_data_out = st_nxt.tx_sh[0];
      st_nxt.ser_data_oe = 1'b1;
    end else if (st_nxt.rx_st == UFAM_RX_SHIFT) begin
      st_nxt.ser_tx = !clk_low;
      st_nxt.ser_data_out = 1'b1;
      st_nxt.ser_data_oe = 1'b0;
    end else begin
      st_nxt.ser_tx = (st_nxt.tx_st == UFAM_TX_RUN) ? st_nxt.tx_sh[0] : 1'b1;
      st_nxt.ser_data_out = 1'b1;
      st_nxt.ser_data_oe = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.rsp.awready <= 1'b1;
      st_r.rsp.wready <= 1'b1;
      st_r.rsp.arready <= 1'b1;
      st_r.slave_own_address <= UFAM_ADDR_RST;
      st_r.smask <= UFAM_MASK_RST;
      st_r.div <= UFAM_DIV_RST;
      st_r.tx_st <= UFAM_TX_IDLE;
      st_r.rx_st <= UFAM_RX_IDLE;
      st_r.rxd_s1 <= 1'b1;
      st_r.rxd_s2 <= 1'b1;
      st_r.rxd_prev <= 1'b1;
      st_r.ser_tx <= 1'b1;
      st_r.ser_data_out <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign axil_rsp = st_r.rsp;
  assign ser_tx = st_r.ser_tx;
  assign ser_data_out = st_r.ser_data_out;
  assign ser_data_oe = st_r.ser_data_oe;
  assign irq = st_r.irq;

endmodule

`default_nettype wire

/* File: verif/ufam_uart_chk.sv */
// checker: bus answers, idle pins, interrupt mask
// assumes a bind onto the ports of ufam_uart
`timescale 1ns/1ps
`default_nettype none
module ufam_uart_chk
  import ufam_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire ufam_axil_req_s axil_req,
  input wire ufam_axil_rsp_s axil_rsp,
  input wire logic ser_data_in,
  input wire logic ser_data_out,
  input wire logic ser_data_oe,
  input wire logic ser_tx,
  input wire logic irq
);
  // ----
  // handshakes
  // ----
  logic w_hs, ar_hs, aw_bad, ar_bad;
  assign w_hs = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
  assign ar_hs = axil_req.arvalid && axil_rsp.arready;
  // the low two address bits are ignored: flags word offsets past the divisor; writes to the status offset are refused by the port but not flagged
  assign aw_bad = {axil_req.awaddr[7:2], 2'b00} > UFAM_OFF_DIV;
  assign ar_bad = {axil_req.araddr[7:2], 2'b00} > UFAM_OFF_DIV;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----
  // properties
  // ----
  a_reset_pins: assert property ($fell(rst) |-> ser_tx && ser_data_out && !ser_data_oe && !irq)
    else $error("pins busy after reset");
  a_pin_idle: assert property (!ser_data_oe |-> ser_data_out) else $error("data out not idle");
  a_wr_answer: assert property (w_hs |-> ##[1:3] axil_rsp.bvalid) else $error("no write answer");
  a_wr_refuse: assert property (w_hs && aw_bad |-> ##[1:3] (axil_rsp.bvalid && axil_rsp.bresp == UFAM_RESP_SLVERR))
    else $error("unmapped write not refused");
  a_aw_busy: assert property (w_hs |=> !axil_rsp.awready) else $error("awready during write");
  a_b_drop: assert property (axil_rsp.bvalid && axil_req.bready |=> !axil_rsp.bvalid) else $error("bvalid stuck");
  a_rd_answer: assert property (ar_hs |=> axil_rsp.rvalid) else $error("no read answer");
  a_rd_refuse: assert property (ar_hs && ar_bad |=> axil_rsp.rresp == UFAM_RESP_SLVERR && axil_rsp.rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rd_busy: assert property (axil_rsp.rvalid |-> !axil_rsp.arready) else $error("arready during read");
  a_irq_mask: assert property (w_hs && axil_req.awaddr == UFAM_OFF_IRQ_EN && axil_req.wdata[2:0] == 3'h0 |-> ##4 !irq)
    else $error("irq while masked");
  c_refused: cover property (w_hs && aw_bad);
  c_irq: cover property ($rose(irq));
  c_tx: cover property ($fell(ser_tx));
endmodule
`default_nettype wire

/* File: verif/ufam_far_end.sv */
// far station on the serial line: sends frames, grabs frames, feeds shift data
// assumes the bench gives the clock and the bit length in cycles; the line idles high
`timescale 1ns/1ps
`default_nettype none
module ufam_far_end (
  input wire logic core_clk,
  input wire logic ser_tx,
  output logic line_drv
);
  initial line_drv = 1'b1;
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // gap above zero delays the start bit
  task automatic send(input logic [8:0] v, input int nb, input logic stop, input int div, input int gap);
    hold(gap);
    for (int i = 0; i < nb + 2; i++) begin
      line_drv <= (i == 0) ? 1'b0 : (i > nb) ? stop : v[i - 1];
      hold(div);
    end
    line_drv <= 1'b1;
    hold(4);
  endtask
  task automatic grab(output logic [7:0] v, input int div);
    @(posedge core_clk iff !ser_tx);
    hold(div / 2);
    for (int i = 0; i < 8; i++) begin
      hold(div);
      v[i] = ser_tx;
    end
    hold(div);
  endtask
  // new bit after each falling shift clock; released to the inverse so no stale level lingers
  task automatic shift_in(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk iff !ser_tx);
      line_drv <= v[i];
      @(posedge core_clk iff ser_tx);
    end
    line_drv <= ~v[7];
  endtask
endmodule
`default_nettype wire

/* File: verif/ufam_uart_tb_top.sv */
// self-checking bench: registers, duplex traffic, framing, address match, shift mode
// assumes ufam_pkg, ufam_uart, ufam_far_end and ufam_uart_chk compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %0h got %0h", nm, e, s); end end
module ufam_uart_tb_top import ufam_pkg::*;;
  localparam int DIV = int'(UFAM_DIV_RST);
  logic core_clk, rst, pin, far_drv, ser_data_out, ser_data_oe, ser_tx, irq;
  ufam_axil_req_s req;
  ufam_axil_rsp_s rsp;
  logic [31:0] seed = 32'h79C1;
  logic [31:0] rv;
  logic [1:0] rr;
  logic [7:0] tx_b, rx_b, got;
  logic [23:0] cases[$] = '{24'h00005A, 24'hF1FAF0, 24'hF1FAF3, 24'hF1FAFF, 24'hF3F9F7, 24'hF1FA00};
  logic [15:0] rst_tab[6] = '{16'h0400, 16'h0800, 16'h0C00, 16'h1000, 16'h1C00, 16'h2010};
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int cnt;
  // shared pin: the port drives it only while its enable is up
  assign pin = ser_data_oe ? ser_data_out : far_drv;
  ufam_uart dut (.core_clk(core_clk), .rst(rst), .axil_req(req), .axil_rsp(rsp), .ser_data_in(pin),
    .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe), .ser_tx(ser_tx), .irq(irq));
  ufam_far_end far (.core_clk(core_clk), .ser_tx(ser_tx), .line_drv(far_drv));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  // ----
  // helpers and model
  // ----
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic hit(int d, int a, int m);
    int g, b;
    g = 1;
    b = 1;
    for (int i = 0; i < 8; i++) begin
      if (m[i] && d[i] != a[i]) g = 0;
      if ((a[i] || m[i]) && !d[i]) b = 0;
    end
    return g || b;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    rr = rsp.bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    rv = rsp.rdata;
    rr = rsp.rresp;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    req = '0;
    req.wstrb = 4'hF;
    req.bready = 1'b1;
    req.rready = 1'b1;
    rst = 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (rst_tab[i]) begin
      rd(rst_tab[i][15:8]);
      `CHK("reset value", 32'(rst_tab[i][7:0]), rv)
    end
    rd(8'h24);
    `CHK("unmapped read", 32'h0, rv)
    wr(8'h30, 32'hFF);
    `CHK("unmapped write", UFAM_RESP_SLVERR, rr)
    wr(UFAM_OFF_IRQ_EN, 32'h0);
    wr(UFAM_OFF_CTRL, 32'h50);
    tx_b = rnd();
    rx_b = rnd();
    fork
      wr(UFAM_OFF_BUF, 32'(tx_b));
      far.grab(got, DIV);
      far.send({1'b0, rx_b}, 8, 1'b1, DIV, 1 + rnd() % 8);
    join
    `CHK("serial out", tx_b, got)
    `CHK("masked irq", 1'b0, irq)
    rd(UFAM_OFF_BUF);
    `CHK("serial in", 32'(rx_b), rv)
    rd(UFAM_OFF_IRQ_ST);
    `CHK("irq status", 32'h3, rv)
    wr(UFAM_OFF_IRQ_EN, 32'h7);
    repeat (2) @(posedge core_clk);
    `CHK("irq raised", 1'b1, irq)
    wr(UFAM_OFF_IRQ_CLR, 32'h7);
    wr(UFAM_OFF_CTRL, 32'h50);
    repeat (2) @(posedge core_clk);
    `CHK("irq cleared", 1'b0, irq)
    wr(UFAM_OFF_IRQ_EN, 32'h1);
    for (int k = 0; k < 2; k++) begin
      wr(UFAM_OFF_PWR, k);
      cnt = 0;
      fork
        far.send({1'b0, rnd()}, 8, 1'b1, DIV, 1);
        begin
          @(posedge core_clk iff !far_drv);
          while (!irq && cnt < 20 * DIV) begin
            @(posedge core_clk);
            cnt++;
          end
        end
      join
      `CHK("done moment", k == 1, cnt > 9 * DIV + DIV / 4)
      wr(UFAM_OFF_IRQ_CLR, 32'h1);
      wr(UFAM_OFF_CTRL, 32'h50);
    end
    // bad stop first, then a good one that must leave the flag alone
    for (int k = 0; k < 2; k++) begin
      far.send({1'b0, rnd()}, 8, k[0], DIV, 1);
      rd(UFAM_OFF_PWR);
      `CHK("framing flag", 32'h3, rv)
      wr(UFAM_OFF_CTRL, 32'h50);
    end
    wr(UFAM_OFF_PWR, 32'h0);
    rd(UFAM_OFF_PWR);
    `CHK("flag cleared", 32'h0, rv)
    repeat (3) cases.push_back({rnd(), rnd(), rnd()});
    foreach (cases[i]) begin
      wr(UFAM_OFF_CTRL, i[0] ? 32'hF0 : 32'hB0);
      wr(UFAM_OFF_SLAVE_OWN_ADDRESS, 32'(cases[i][23:16]));
      wr(UFAM_OFF_SMASK, 32'(cases[i][15:8]));
      rd(UFAM_OFF_SMASK);
      `CHK("mask readback", 32'(cases[i][15:8]), rv)
      far.send({1'b1, cases[i][7:0]}, 9, 1'b1, DIV, 1);
      rd(UFAM_OFF_CTRL);
      `CHK("address hit", hit(cases[i][7:0], cases[i][23:16], cases[i][15:8]), rv[0])
      wr(UFAM_OFF_CTRL, i[0] ? 32'hF0 : 32'hB0);
      far.send({1'b0, cases[i][7:0]}, 9, 1'b1, DIV, 1);
      rd(UFAM_OFF_CTRL);
      `CHK("data with compare", 1'b0, rv[0])
    end
    wr(UFAM_OFF_CTRL, 32'h70);
    for (int k = 0; k < 2; k++) begin
      far.send({1'b0, cases[$][23:16]}, 8, k[0], DIV, 1);
      rd(UFAM_OFF_CTRL);
      `CHK("stop as marker", k[0], rv[0])
    end
    wr(UFAM_OFF_CTRL, 32'h30);
    rx_b = rnd();
    far.shift_in(rx_b);
    rv = 32'h0;
    for (int t = 0; t < 16 && !rv[0]; t++) rd(UFAM_OFF_CTRL);
    `CHK("shift done", 1'b1, rv[0])
    rd(UFAM_OFF_BUF);
    `CHK("shift data", 32'(rx_b), rv)
    // shift mode transmit: data pin driven, read at each rising shift clock
    wr(UFAM_OFF_CTRL, 32'h0);
    tx_b = rnd();
    wr(UFAM_OFF_BUF, 32'(tx_b));
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk iff !ser_tx);
      @(posedge core_clk iff ser_tx);
      got[i] = ser_data_out;
      `CHK("shift drive", 1'b1, ser_data_oe)
    end
    `CHK("shift out", tx_b, got)
    complete_run();
  end
endmodule
bind ufam_uart ufam_uart_chk chk (.core_clk(core_clk), .rst(rst), .axil_req(axil_req), .axil_rsp(axil_rsp),
  .ser_data_in(ser_data_in), .ser_data_out(ser_data_out), .ser_data_oe(ser_data_oe), .ser_tx(ser_tx), .irq(irq));
`default_nettype wire
